// *** core/spisl_pkg.sv ***
// Constants and carrier types shared by the slave serial port.
// Assumes the port sits behind plain control and status wires, no bus.
//
// Overview of operation
// - Shift on master clock; flag each completed byte.
// - Shifter runs from pin clock during sleep.
// - Second burst shifts out previous received byte.
// - Overwrite enable lets writes replace unread byte.
// - Select high discards partial byte, restarts.
// - Slave active only with mode 0100.
// - Select low drives data out, enables shifting.
// - Select high floats data out at once.
// - Select high resets the shifter only.
// - Select high or disable zeroes bit counter.
package spisl_pkg;

    // ------------------------------------------------------------------
    // Encodings and widths
    // ------------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int CNT_W = 3;
    localparam int MODE_W = 4;
    localparam logic [MODE_W-1:0] MODE_SLAVE_SEL = 4'h4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [BYTE_W-1:0] BUF_RST = 8'h00;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic port_enable;
        logic [MODE_W-1:0] mode;
        logic clock_idle_polarity;
        logic buffer_overwrite_enable;
    } spisl_ctrl_t;

    typedef struct packed {
        logic transfer_done_flag;
        logic overflow;
        logic write_collision;
        logic buffer_full;
    } spisl_stat_t;

endpackage : spisl_pkg

// *** core/spisl_sync.sv ***
// Two-stage synchroniser for a bundle of independent levels.
// Assumes each bit is a level or a toggle that changes slowly.
`timescale 1ns/1ps
module spisl_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule : spisl_sync

// *** core/spisl_slave_port.sv ***
// Slave-mode serial port: shifter on the master's clock, buffer and flags
// on the system clock.
// Assumes software writes the transfer buffer only while select is high.
`timescale 1ns/1ps
module spisl_slave_port
    import spisl_pkg::*;
(
    // System clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Serial pins
    input wire logic serial_clock_pin_i,
    input wire logic slave_select_pin_n_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    // Control
    input wire spisl_ctrl_t ctrl_i,
    input wire logic buf_wr_i,
    input wire logic [BYTE_W-1:0] buf_wdata_i,
    input wire logic buf_rd_i,
    input wire logic flag_clr_i,
    // Status
    output logic [BYTE_W-1:0] buf_rdata_o,
    output spisl_stat_t stat_o,
    output logic serial_clock_level_o
);

    // ------------------------------------------------------------------
    // Mode decode and link reset
    // ------------------------------------------------------------------
    logic active_r;
    logic link_clk;
    logic link_rst;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_r <= 1'b0;
        end else begin
            active_r <= ctrl_i.port_enable &&
                (ctrl_i.mode == MODE_SLAVE_SEL);
        end
    end

    // The active edge is always the idle-to-active transition of the pin.
    assign link_clk = serial_clock_pin_i ^ ctrl_i.clock_idle_polarity;
    // Select high or a disabled port holds the shifter in reset.
    assign link_rst = rst_i | slave_select_pin_n_i | ~active_r;

    // Driven while selected; float at once when select rises, mid-byte too.
    assign serial_data_out_oe_o = active_r & ~slave_select_pin_n_i;

    // ------------------------------------------------------------------
    // Link-domain shifter
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] cnt_r;
    logic [BYTE_W-2:0] rx_sh_r;
    logic [BYTE_W-1:0] tx_sh_r;
    logic [BYTE_W-1:0] last_rx_r;
    logic first_r;
    logic [BYTE_W-1:0] rx_hold_r;
    logic done_tgl_r;
    logic [BYTE_W-1:0] buf_r;
    logic [BYTE_W-1:0] tx_src;

    // First byte of a frame sends the buffer; later bytes echo what came
    // in, so a chain of slaves acts as one long shift register.
    assign tx_src = first_r ? buf_r : last_rx_r;
    assign serial_data_out_o = (cnt_r == CNT_ZERO) ? tx_src[BYTE_W-1]
                                                   : tx_sh_r[BYTE_W-1];

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            cnt_r <= CNT_ZERO;
            rx_sh_r <= '0;
            tx_sh_r <= '0;
            first_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + CNT_ONE;
            rx_sh_r <= {rx_sh_r[BYTE_W-3:0], serial_data_in_i};
            if (cnt_r == CNT_ZERO) begin
                tx_sh_r <= {tx_src[BYTE_W-2:0], 1'b0};
            end else begin
                tx_sh_r <= {tx_sh_r[BYTE_W-2:0], 1'b0};
            end
            if (cnt_r == CNT_LAST) begin
                first_r <= 1'b0;
            end
        end
    end

    // Completed bytes and the event toggle survive select, so a byte that
    // finished just before select rose is still delivered.
    always_ff @(posedge link_clk or posedge rst_i) begin
        if (rst_i) begin
            rx_hold_r <= BUF_RST;
            last_rx_r <= BUF_RST;
            done_tgl_r <= 1'b0;
        end else if (!slave_select_pin_n_i && active_r &&
                     cnt_r == CNT_LAST) begin
            rx_hold_r <= {rx_sh_r, serial_data_in_i};
            last_rx_r <= {rx_sh_r, serial_data_in_i};
            done_tgl_r <= ~done_tgl_r;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into the system domain
    // ------------------------------------------------------------------
    logic tgl_sync;
    logic tgl_seen_r;
    logic done_evt;

    spisl_sync #(.W(2)) u_sync (
        .clk_i(sys_clk_i),
        .rst_i(rst_i),
        .d_i({done_tgl_r, serial_clock_pin_i}),
        .q_o({tgl_sync, serial_clock_level_o})
    );

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tgl_seen_r <= 1'b0;
        end else begin
            tgl_seen_r <= tgl_sync;
        end
    end

    // rx_hold_r is stable for a whole byte time after the toggle moves.
    assign done_evt = tgl_sync ^ tgl_seen_r;

    // ------------------------------------------------------------------
    // Transfer buffer and flags
    // ------------------------------------------------------------------
    logic full_r;
    logic done_r;
    logic ovf_r;
    logic wcol_r;
    logic may_load;

    assign may_load = ~full_r | ctrl_i.buffer_overwrite_enable;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            buf_r <= BUF_RST;
        end else if (done_evt && may_load) begin
            buf_r <= rx_hold_r;
        end else if (buf_wr_i && may_load) begin
            buf_r <= buf_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            full_r <= 1'b0;
        end else if (done_evt && may_load) begin
            full_r <= 1'b1;
        end else if (buf_rd_i) begin
            full_r <= 1'b0;
        end
    end

    // A hardware set in the clearing cycle wins over the clear.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_r <= 1'b0;
            ovf_r <= 1'b0;
            wcol_r <= 1'b0;
        end else begin
            done_r <= done_evt | (done_r & ~flag_clr_i);
            ovf_r <= (done_evt & ~may_load) | (ovf_r & ~flag_clr_i);
            wcol_r <= (buf_wr_i & ~may_load) | (wcol_r & ~flag_clr_i);
        end
    end

    assign buf_rdata_o = buf_r;
    assign stat_o = '{transfer_done_flag: done_r, overflow: ovf_r,
                      write_collision: wcol_r, buffer_full: full_r};

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_done_set;
        @(posedge sys_clk_i) disable iff (rst_i)
        done_evt |=> done_r;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done flag not set after completed byte");

    property p_ovf_keep;
        @(posedge sys_clk_i) disable iff (rst_i)
        done_evt && full_r && !ctrl_i.buffer_overwrite_enable
            |=> ovf_r && buf_r == $past(buf_r);
    endproperty
    a_ovf_keep: assert property (p_ovf_keep)
        else $error("overflow not flagged or buffer overwritten");

    property p_buffer_overwrite_enable_wr;
        @(posedge sys_clk_i) disable iff (rst_i)
        buf_wr_i && ctrl_i.buffer_overwrite_enable && !done_evt
            |=> buf_r == $past(buf_wdata_i);
    endproperty
    a_buffer_overwrite_enable_wr: assert property (p_buffer_overwrite_enable_wr)
        else $error("overwrite enabled write not accepted");

    property p_float;
        @(posedge sys_clk_i) disable iff (rst_i)
        slave_select_pin_n_i |-> !serial_data_out_oe_o && cnt_r == CNT_ZERO;
    endproperty
    a_float: assert property (p_float)
        else $error("data out driven or counter live with select high");

    property p_drive;
        @(posedge sys_clk_i) disable iff (rst_i)
        active_r && !slave_select_pin_n_i |-> serial_data_out_oe_o &&
            (!first_r || cnt_r != CNT_ZERO ||
             serial_data_out_o == buf_r[BYTE_W-1]);
    endproperty
    a_drive: assert property (p_drive)
        else $error("data out not driven with buffer bit while selected");

    property p_mode;
        @(posedge sys_clk_i) disable iff (rst_i)
        ##1 $past(ctrl_i.mode) != MODE_SLAVE_SEL
            |-> !serial_data_out_oe_o && cnt_r == CNT_ZERO && first_r;
    endproperty
    a_mode: assert property (p_mode)
        else $error("slave active with wrong mode");

    property p_disable;
        @(posedge sys_clk_i) disable iff (rst_i)
        !active_r |-> cnt_r == CNT_ZERO && first_r;
    endproperty
    a_disable: assert property (p_disable)
        else $error("counter not held at zero while disabled");

    property p_capture;
        @(posedge link_clk) disable iff (link_rst)
        cnt_r == CNT_LAST
            |=> rx_hold_r == $past({rx_sh_r, serial_data_in_i})
                && cnt_r == CNT_ZERO;
    endproperty
    a_capture: assert property (p_capture)
        else $error("received byte not captured at eighth bit");

    property p_echo;
        @(posedge link_clk) disable iff (link_rst)
        cnt_r == CNT_LAST |=> serial_data_out_o == $past(rx_sh_r[BYTE_W-2]);
    endproperty
    a_echo: assert property (p_echo)
        else $error("second burst does not echo received byte");

endmodule : spisl_slave_port

// *** bench/spisl_master_model.sv ***
// Behavioural master on the far side of the slave serial port.
// Assumes the bench calls one task at a time and sets polarity first.
`timescale 1ns/1ps
module spisl_master_model (
    // Setup
    input wire logic cpol_i,
    // Serial pins
    input wire logic miso_i,
    output logic sclk_o,
    output logic ss_n_o,
    output logic mosi_o
);
    // ------------------------------------------------------------------
    // Frame generation
    // ------------------------------------------------------------------
    initial begin
        sclk_o = 1'b0;
        ss_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    task automatic idle();
        sclk_o = cpol_i;
    endtask : idle

    // Sends the top nb bits of tx, MSB first, one bit per 48 ns.
    // The clock only toggles inside a frame, as a real master does.
    task automatic frame(input logic [15:0] tx, input int nb,
                         output logic [15:0] rx);
        rx = '0;
        sclk_o = cpol_i;
        #30 ss_n_o = 1'b0;
        for (int k = 0; k < nb; k++) begin
            mosi_o = tx[15-k];
            #24 rx = {rx[14:0], miso_i};
            sclk_o = ~cpol_i;
            #24 sclk_o = cpol_i;
        end
        ss_n_o = 1'b1;
        mosi_o = ~mosi_o;
    endtask : frame
endmodule : spisl_master_model

// *** bench/spisl_slave_port_tb_top.sv ***
// Self-checking bench for the slave serial port with a master model.
// Assumes flags settle within six system clocks after a byte ends.
`timescale 1ns/1ps
module spisl_slave_port_tb_top;
    import spisl_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sclk, ss_n, mosi, sdo, oe, clk_lvl;
    logic buf_wr_i = 1'b0;
    logic buf_rd_i = 1'b0;
    logic flag_clr_i = 1'b0;
    logic [7:0] buf_wdata_i = 8'h00;
    logic [7:0] buf_rdata_o, a, b, w;
    logic [15:0] rx;
    spisl_ctrl_t ctrl_i = '0;
    spisl_stat_t stat_o;
    int miscompares = 0;
    int n_checks = 0;
    // A pull-up holds the data line while the port floats it.
    wire logic miso = oe ? sdo : 1'b1;

    always #12.5 sys_clk_i = ~sys_clk_i;

    spisl_slave_port dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .serial_clock_pin_i(sclk), .slave_select_pin_n_i(ss_n),
        .serial_data_in_i(mosi), .serial_data_out_o(sdo),
        .serial_data_out_oe_o(oe), .ctrl_i(ctrl_i),
        .buf_wr_i(buf_wr_i), .buf_wdata_i(buf_wdata_i),
        .buf_rd_i(buf_rd_i), .flag_clr_i(flag_clr_i),
        .buf_rdata_o(buf_rdata_o), .stat_o(stat_o),
        .serial_clock_level_o(clk_lvl));

    spisl_master_model m (.cpol_i(ctrl_i.clock_idle_polarity),
        .miso_i(miso), .sclk_o(sclk), .ss_n_o(ss_n), .mosi_o(mosi));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // Status word as the flags should stand, in struct order.
    function automatic logic [7:0] exp_stat(input logic d, input logic o,
                                            input logic c, input logic f);
        return {4'h0, d, o, c, f};
    endfunction : exp_stat

    task automatic chk_stat(input logic [7:0] e);
        chk({4'h0, stat_o}, e);
    endtask : chk_stat

    task automatic chk_bit(input logic g, input logic e);
        chk({7'h0, g}, {7'h0, e});
    endtask : chk_bit

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // Kind 0 writes the buffer, 1 reads it, 2 clears the flags.
    task automatic pulse(input int kind, input logic [7:0] d);
        @(negedge sys_clk_i);
        buf_wr_i = (kind == 0);
        buf_rd_i = (kind == 1);
        flag_clr_i = (kind == 2);
        buf_wdata_i = d;
        @(negedge sys_clk_i);
        buf_wr_i = 1'b0;
        buf_rd_i = 1'b0;
        flag_clr_i = 1'b0;
    endtask : pulse

    task automatic wait_done();
        int i;
        for (i = 0; i < 40 && stat_o.transfer_done_flag !== 1'b1; i++) begin
            @(negedge sys_clk_i);
        end
        if (i == 40) begin
            miscompares++;
            finish_test();
        end
        repeat (6) @(negedge sys_clk_i);
    endtask : wait_done

    // ------------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h2afd));
        repeat (12) @(negedge sys_clk_i);
        rst_i = 1'b0;
        chk_stat(8'h00);
        chk(buf_rdata_o, 8'h00);
        chk_bit(oe, 1'b0);
        for (int it = 0; it < 6; it++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            w = 8'($urandom);
            ctrl_i = '{1'b0, MODE_SLAVE_SEL, it[0], 1'b0};
            // Let the new polarity reach the model before it parks the clock.
            #1 m.idle();
            repeat (3) @(negedge sys_clk_i);
            ctrl_i.port_enable = 1'b1;
            chk_bit(clk_lvl, it[0]);
            pulse(2, 8'h00);
            pulse(1, 8'h00);
            chk_stat(8'h00);
            pulse(0, w);
            chk(buf_rdata_o, w);
            m.frame({a, b}, 16, rx);
            chk(rx[15:8], w);
            chk(rx[7:0], a);
            wait_done();
            chk(buf_rdata_o, a);
            chk_stat(exp_stat(1'b1, 1'b1, 1'b0, 1'b1));
            pulse(0, b);
            chk_stat(exp_stat(1'b1, 1'b1, 1'b1, 1'b1));
            chk(buf_rdata_o, a);
            ctrl_i.buffer_overwrite_enable = 1'b1;
            pulse(0, b);
            chk(buf_rdata_o, b);
            m.frame({w, 8'h00}, 3, rx);
            #1 chk_bit(oe, 1'b0);
            pulse(2, 8'h00);
            pulse(1, 8'h00);
            m.frame({a, 8'h00}, 8, rx);
            chk(rx[7:0], b);
            wait_done();
            chk(buf_rdata_o, a);
            chk_stat(exp_stat(1'b1, 1'b0, 1'b0, 1'b1));
            ctrl_i.mode = MODE_SLAVE_SEL ^ 4'(it + 1);
            ctrl_i.port_enable = it[1];
            pulse(2, 8'h00);
            m.frame({b, 8'h00}, 8, rx);
            repeat (8) @(negedge sys_clk_i);
            chk_bit(stat_o.transfer_done_flag, 1'b0);
            chk(buf_rdata_o, a);
            $display("test %0d done", it);
        end
        finish_test();
    end
endmodule : spisl_slave_port_tb_top
